// *** hdl/event_flag_bank.v ***
// Bank of event flags: sticky bits, live bits, or constant zero.
// Assumes set pulses and the clear strobe share the master clock.
`timescale 1ns/1ps
`default_nettype none

module event_flag_bank #(
  parameter integer  N      = 8,
  parameter [N-1:0]  USED   = 8'hBB,
  parameter [N-1:0]  STICKY = 8'hAB
) (
  input  wire          i_mclk,    // Master clock
  input  wire          i_arst_n,  // Async reset, active low
  input  wire [N-1:0]  i_set,     // Event pulses
  input  wire [N-1:0]  i_live,    // Levels for live bits
  input  wire          i_clear,   // Clear all sticky bits
  output wire [N-1:0]  o_flags    // Current flags
);

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_flag
      if (!USED[i]) begin : g_none
        assign o_flags[i] = 1'b0;
      end else if (STICKY[i]) begin : g_sticky
        reg q_reg;
        // Set beats a clear in the same cycle
        always @(posedge i_mclk or negedge i_arst_n) begin
          if (!i_arst_n)
            q_reg <= 1'b0;
          else
            q_reg <= i_set[i] | (q_reg & ~i_clear);
        end
        assign o_flags[i] = q_reg;
      end else begin : g_live
        reg q_reg;
        always @(posedge i_mclk or negedge i_arst_n) begin
          if (!i_arst_n)
            q_reg <= 1'b0;
          else
            q_reg <= i_live[i];
        end
        assign o_flags[i] = q_reg;
      end
    end
  endgenerate

endmodule // event_flag_bank

`default_nettype wire

// *** hdl/meter_irq_defs.vh ***
// Register offsets, field positions and reset values for the
// metering mode and interrupt block. Definitions only.
`ifndef METER_IRQ_DEFS_VH
`define METER_IRQ_DEFS_VH

// Register port geometry
`define ADDR_W          5
`define DATA_W          16

// Register offsets
`define OFS_FLAGS       5'h04
`define OFS_FLAGS_RC    5'h05
`define OFS_OPCFG       5'h06
`define OFS_MASK        5'h0A

// Reset values
`define OPCFG_RST       16'h0000
`define MASK_RST        8'h00

// Operating configuration fields
`define BIT_TEMP_START  5
`define BIT_CAL_MODE    7
`define BIT_CH_SWAP     10
`define POS_RATE_LO     11
`define POS_RATE_HI     12
`define POS_SRC_LO      13
`define POS_SRC_HI      14
`define BIT_TEST        15
`define LOW_CFG_W       10

// Waveform source codes
`define SRC_POWER       2'h0
`define SRC_RSVD        2'h1
`define SRC_CH1         2'h2
`define SRC_CH2         2'h3

// Flag positions, shared by status, clear-on-read and mask
`define FLG_HALF        0
`define FLG_SAG         1
`define FLG_WAVEFORM_SAMPLE_FLAG        3
`define FLG_ZX          4
`define FLG_TEMP        5
`define FLG_OVF         7
`define FLG_W           8
`define FLG_USED        8'hBB
`define FLG_STICKY      8'hAB

// Waveform update divider
`define WAVE_DIV_BASE   128
`define WAVE_CNT_W      10

`endif

// *** hdl/meter_mode_irq.v ***
// Mode configuration fields and interrupt status/enable logic
// of an energy metering device, with its open-drain request.
// Assumes the serial framing logic presents one-cycle read and
// write strobes with address and data, all on the master clock,
// and that detectors deliver one-cycle event pulses.
//
// Notes on behaviour
// - Swap bit crosses both analog input pairs
// - Rate field divides clock 128 to 1024
// - Source field picks power, channel one, two
// - Every event but integration end outside calibration mode sets its status flag
// - Request low when enabled flag is set
// - Bit 0 on energy MSB rising
// - Bit 1 on dip or lost crossings
// - Calibration mode: bit 1 on integration end
// - Bit 3 on each new waveform sample
// - Bit 4 follows zero-crossing output
// - Bit 5 on finished temperature conversion
// - Bit 7 on energy register overflow
// - Status, clear and mask share positions
// - Mode bit 7 selects calibration mode
`timescale 1ns/1ps
`default_nettype none
`include "meter_irq_defs.vh"

module meter_mode_irq #(
  parameter integer CNT_W = `WAVE_CNT_W
) (
  input  wire                 i_mclk,         // Master clock, 100 MHz
  input  wire                 i_arst_n,       // Async reset, active low
  input  wire [`ADDR_W-1:0]   i_reg_addr,     // Register address
  input  wire [`DATA_W-1:0]   i_reg_wdata,    // Write data
  input  wire                 i_reg_wr,       // Write strobe, one cycle
  input  wire                 i_reg_rd,       // Read strobe, one cycle
  input  wire                 i_energy_msb,   // Energy register MSB level
  input  wire                 i_energy_ovf,   // Energy overflow pulse
  input  wire                 i_sag_evt,      // Voltage dip pulse
  input  wire                 i_nozx_evt,     // Missing crossings pulse
  input  wire                 i_cal_done,     // Integration end pulse
  input  wire                 i_zx_level,     // Zero-crossing output level
  input  wire                 i_temp_done,    // Temperature result pulse
  output reg  [`DATA_W-1:0]   o_reg_rdata,    // Read data
  output reg                  o_reg_rvalid,   // Read data valid pulse
  output reg                  o_irq_out,      // Request pin level, always 0
  output reg                  o_irq_oe,       // Request pin pulled low
  output reg                  o_ch_swap,      // Inputs crossed to converters
  output reg                  o_adc1_from_ch2,// Converter 1 sees channel 2
  output reg                  o_adc2_from_ch1,// Converter 2 sees channel 1
  output reg  [1:0]           o_wave_src,     // Waveform source select
  output reg                  o_wave_strobe,  // Load waveform sample pulse
  output reg                  o_cal_mode,     // Calibration mode
  output reg                  o_test_mode,    // Factory test mode
  output reg  [`LOW_CFG_W-1:0] o_low_cfg      // Lower mode bits
);

  // Operating configuration and mask
  reg  [`DATA_W-1:0] opcfg_reg;
  reg  [`DATA_W-1:0] opcfg_next;
  reg  [`FLG_W-1:0]  mask_reg;
  reg  [`FLG_W-1:0]  mask_next;

  // Event edge and pulse capture
  reg                msb_prev_reg;
  wire               half_full_evt;
  wire               wave_tick;
  wire               sag_bit_evt;
  reg  [`FLG_W-1:0]  set_vec;
  reg  [`FLG_W-1:0]  live_vec;
  wire [`FLG_W-1:0]  flags;
  wire               clr_on_read;

  // Read path
  reg  [`DATA_W-1:0] rdata_next;

  // Field views
  wire [1:0]         rate_sel;
  wire [1:0]         src_sel;
  wire               cal_mode;
  wire               src_valid;

  function is_addr;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  assign rate_sel  = opcfg_reg[`POS_RATE_HI:`POS_RATE_LO];
  assign src_sel   = opcfg_reg[`POS_SRC_HI:`POS_SRC_LO];
  assign cal_mode  = opcfg_reg[`BIT_CAL_MODE];
  // reserved source code takes no samples
  assign src_valid = (src_sel != `SRC_RSVD);

  // Configuration write; temperature start self-clears
  always @* begin
    opcfg_next = opcfg_reg;
    if (i_reg_wr && is_addr(i_reg_addr, `OFS_OPCFG)) begin
      opcfg_next = i_reg_wdata;
    end
    if (i_temp_done) begin
      opcfg_next[`BIT_TEMP_START] = 1'b0;
    end
  end

  always @* begin
    mask_next = mask_reg;
    if (i_reg_wr && is_addr(i_reg_addr, `OFS_MASK)) begin
      mask_next = i_reg_wdata[`FLG_W-1:0] & `FLG_USED;
    end
  end

  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opcfg_reg <= `OPCFG_RST;
      mask_reg  <= `MASK_RST;
    end else begin
      opcfg_reg <= opcfg_next;
      mask_reg  <= mask_next;
    end
  end

  wave_rate_divider #(
    .CNT_W    (CNT_W),
    .BASE_DIV (`WAVE_DIV_BASE)
  ) u_rate (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_run      (src_valid),
    .i_rate_sel (rate_sel),
    .o_tick     (wave_tick)
  );

  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      msb_prev_reg <= 1'b0;
    else
      msb_prev_reg <= i_energy_msb;
  end
  assign half_full_evt = i_energy_msb & ~msb_prev_reg;

  // integration end only in calibration mode
  assign sag_bit_evt = i_sag_evt | i_nozx_evt | (cal_mode & i_cal_done);

  // one position map for all three registers
  always @* begin
    set_vec              = {`FLG_W{1'b0}};
    live_vec             = {`FLG_W{1'b0}};
    set_vec[`FLG_HALF]   = half_full_evt;
    set_vec[`FLG_SAG]    = sag_bit_evt;
    set_vec[`FLG_WAVEFORM_SAMPLE_FLAG]   = wave_tick;
    set_vec[`FLG_TEMP]   = i_temp_done;
    set_vec[`FLG_OVF]    = i_energy_ovf;
    // crossing flag follows the output level
    live_vec[`FLG_ZX]    = i_zx_level;
  end

  // read of clear-on-read register clears flags
  assign clr_on_read = i_reg_rd && is_addr(i_reg_addr, `OFS_FLAGS_RC);

  // bits 2 and 6 never exist
  event_flag_bank #(
    .N      (`FLG_W),
    .USED   (`FLG_USED),
    .STICKY (`FLG_STICKY)
  ) u_flags (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_set    (set_vec),
    .i_live   (live_vec),
    .i_clear  (clr_on_read),
    .o_flags  (flags)
  );

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_next = {`DATA_W{1'b0}};
    if (is_addr(i_reg_addr, `OFS_FLAGS)) begin
      rdata_next[`FLG_W-1:0] = flags;
    end else if (is_addr(i_reg_addr, `OFS_FLAGS_RC)) begin
      rdata_next[`FLG_W-1:0] = flags;
    end else if (is_addr(i_reg_addr, `OFS_OPCFG)) begin
      rdata_next = opcfg_reg;
    end else if (is_addr(i_reg_addr, `OFS_MASK)) begin
      rdata_next[`FLG_W-1:0] = mask_reg;
    end
  end

  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata  <= {`DATA_W{1'b0}};
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_next;
      end
    end
  end

  // Open-drain request: pin level fixed low, enable does the work
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq_out <= 1'b0;
      o_irq_oe  <= 1'b0;
    end else begin
      o_irq_out <= 1'b0;
      // any enabled flag pulls the pin low
      // released once no enabled flag remains
      o_irq_oe  <= |(flags & mask_reg);
    end
  end

  // Configuration outputs toward the analog and waveform paths
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ch_swap       <= 1'b0;
      o_adc1_from_ch2 <= 1'b0;
      o_adc2_from_ch1 <= 1'b0;
      o_wave_src      <= `SRC_POWER;
      o_wave_strobe   <= 1'b0;
      o_cal_mode      <= 1'b0;
      o_test_mode     <= 1'b0;
      o_low_cfg       <= {`LOW_CFG_W{1'b0}};
    end else begin
      // both converters take the other pair
      o_ch_swap       <= opcfg_reg[`BIT_CH_SWAP];
      o_adc1_from_ch2 <= opcfg_reg[`BIT_CH_SWAP];
      o_adc2_from_ch1 <= opcfg_reg[`BIT_CH_SWAP];
      // source select to the waveform path
      o_wave_src      <= src_sel;
      // sample load aligned with the flag
      o_wave_strobe   <= wave_tick;
      o_cal_mode      <= cal_mode;
      o_test_mode     <= opcfg_reg[`BIT_TEST];
      o_low_cfg       <= opcfg_reg[`LOW_CFG_W-1:0];
    end
  end

endmodule // meter_mode_irq

`default_nettype wire

// *** hdl/wave_rate_divider.v ***
// Waveform update tick: one pulse every base<<sel master clocks.
// Assumes the select is stable or restarts cleanly on change.
`timescale 1ns/1ps
`default_nettype none

module wave_rate_divider #(
  parameter integer        CNT_W    = 10,
  parameter [CNT_W:0]      BASE_DIV = 128
) (
  input  wire              i_mclk,      // Master clock
  input  wire              i_arst_n,    // Async reset, active low
  input  wire              i_run,       // Ticks allowed
  input  wire [1:0]        i_rate_sel,  // Divide select
  output reg               o_tick       // One-cycle sample pulse
);

  reg  [CNT_W-1:0] cnt_reg;
  wire [CNT_W:0]   span;
  wire [CNT_W:0]   last;
  wire             at_end;

  assign span   = BASE_DIV << i_rate_sel;
  assign last   = span - {{CNT_W{1'b0}}, 1'b1};
  // Greater-or-equal covers a shortened period mid-count
  assign at_end = ({1'b0, cnt_reg} >= last);

  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg <= {CNT_W{1'b0}};
      o_tick  <= 1'b0;
    end else if (!i_run) begin
      cnt_reg <= {CNT_W{1'b0}};
      o_tick  <= 1'b0;
    end else if (at_end) begin
      cnt_reg <= {CNT_W{1'b0}};
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      o_tick  <= 1'b0;
    end
  end

endmodule // wave_rate_divider

`default_nettype wire

// *** tb/host_model.sv ***
// Host side of the register port: write, read and service tasks.
// Assumes the master clock is shared with the device.
`timescale 1ns/1ps
`default_nettype none
`include "meter_irq_defs.vh"
module host_model (
  input  wire logic               i_mclk,   // Master clock
  output var  logic [`ADDR_W-1:0] o_addr,   // Address
  output var  logic [`DATA_W-1:0] o_wdata,  // Write data
  output var  logic               o_wr,     // Write strobe
  output var  logic               o_rd,     // Read strobe
  input  wire logic [`DATA_W-1:0] i_rdata,  // Read data
  input  wire logic               i_rvalid  // Read valid
);
  initial begin
    {o_wr, o_rd} = 2'b00;
    {o_addr, o_wdata} = '0;
  end
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(posedge i_mclk);
    o_addr  <= a;
    o_wdata <= (a == `OFS_OPCFG) ? (d & 16'h7FFF) : d;
    o_wr    <= 1'b1;
    @(posedge i_mclk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_mclk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = (i_rvalid === 1'b1) ? i_rdata : 16'hDEAD;
  endtask
  task automatic service(output logic [`DATA_W-1:0] s, output logic [`DATA_W-1:0] c);
    rd(`OFS_FLAGS, s);
    rd(`OFS_FLAGS_RC, c);
  endtask
endmodule // host_model
`default_nettype wire

// *** tb/meter_irq_monitor.sv ***
// Port-level checks of the mode and interrupt block.
// Assumes one master clock domain and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "meter_irq_defs.vh"
module meter_irq_monitor (
  input wire logic [`ADDR_W-1:0] i_reg_addr,   // Address
  input wire logic               i_mclk,       // Clock
  input wire logic               i_arst_n,     // Reset
  input wire logic [`DATA_W-1:0] i_reg_wdata,  // Write data
  input wire logic               i_reg_wr,     // Write
  input wire logic               i_reg_rd,     // Read
  input wire logic               i_energy_msb, // Energy MSB
  input wire logic               i_energy_ovf, // Overflow
  input wire logic               i_sag_evt,    // Dip
  input wire logic               i_nozx_evt,   // No crossings
  input wire logic               i_cal_done,   // Cal end
  input wire logic               i_zx_level,   // Crossing level
  input wire logic               i_temp_done,  // Temp done
  input wire logic [`DATA_W-1:0] o_reg_rdata,  // Read data
  input wire logic               o_reg_rvalid, // Read valid
  input wire logic               o_irq_out,    // Pin value
  input wire logic               o_irq_oe,     // Pin enable
  input wire logic               o_ch_swap,    // Swap
  input wire logic               o_adc1_from_ch2, // Conv 1
  input wire logic               o_adc2_from_ch1, // Conv 2
  input wire logic [1:0]         o_wave_src,   // Source
  input wire logic               o_wave_strobe,// Sample tick
  input wire logic               o_cal_mode    // Cal mode
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  wire cfg_wr = i_reg_wr && (i_reg_addr == `OFS_OPCFG);
  wire rc_rd  = i_reg_rd && (i_reg_addr == `OFS_FLAGS_RC);
  wire pulses = i_energy_ovf | i_sag_evt | i_nozx_evt | i_cal_done | i_temp_done | i_zx_level;
  a_pin_drive_low: assert property (o_irq_out == 1'b0)
    else $error("request pin driven high");
  a_swap_pairs: assert property (o_adc1_from_ch2 == o_ch_swap && o_adc2_from_ch1 == o_ch_swap)
    else $error("converter routing differs from swap");
  a_swap_write: assert property (cfg_wr |-> ##2 o_ch_swap == $past(i_reg_wdata[10], 2))
    else $error("swap output wrong after write");
  a_source_write: assert property (cfg_wr |-> ##2 o_wave_src == $past(i_reg_wdata[14:13], 2))
    else $error("source output wrong after write");
  a_cal_write: assert property (cfg_wr |-> ##2 o_cal_mode == $past(i_reg_wdata[7], 2))
    else $error("calibration output wrong after write");
  a_read_valid_pulse: assert property (o_reg_rvalid == $past(i_reg_rd))
    else $error("read valid not one cycle after read");
  a_spare_bits_zero: assert property (o_reg_rvalid && $past(i_reg_addr) inside {`OFS_FLAGS, `OFS_FLAGS_RC}
    |-> (o_reg_rdata & 16'hFF44) == 16'h0000)
    else $error("unassigned flag bit set");
  a_overflow_seen: assert property (i_energy_ovf ##2 (i_reg_rd && i_reg_addr == `OFS_FLAGS) |=> o_reg_rdata[7])
    else $error("overflow flag missing");
  a_zx_tracks: assert property (i_reg_rd && i_reg_addr == `OFS_FLAGS |=> o_reg_rdata[4] == $past(i_zx_level, 2))
    else $error("crossing flag does not follow level");
  a_release_after_clear: assert property ((rc_rd && !pulses && !$rose(i_energy_msb)) ##1 !o_wave_strobe
    |=> !o_irq_oe)
    else $error("request held after clear");
  a_strobe_gap: assert property (o_wave_strobe |=> !o_wave_strobe [*8])
    else $error("sample ticks too close");
  c_irq_raised: cover property ($rose(o_irq_oe));
  c_clear_read: cover property (rc_rd ##2 !o_irq_oe);
  c_wave_tick: cover property (o_wave_strobe);
endmodule // meter_irq_monitor
bind meter_mode_irq meter_irq_monitor u_mon (.i_reg_addr, .i_mclk, .i_arst_n, .i_reg_wdata, .i_reg_wr,
  .i_reg_rd, .i_energy_msb, .i_energy_ovf, .i_sag_evt, .i_nozx_evt, .i_cal_done, .i_zx_level, .i_temp_done,
  .o_reg_rdata, .o_reg_rvalid, .o_irq_out, .o_irq_oe, .o_ch_swap, .o_adc1_from_ch2, .o_adc2_from_ch1,
  .o_wave_src, .o_wave_strobe, .o_cal_mode);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the metering mode and interrupt block.
// Assumes host_model drives the register port.
`timescale 1ns/1ps
`default_nettype none
`include "meter_irq_defs.vh"
module testbench;
  logic               i_mclk, i_arst_n, reg_wr, reg_rd, reg_rvalid, zx;
  logic [`ADDR_W-1:0] reg_addr;
  logic [`DATA_W-1:0] reg_wdata, reg_rdata, s, c;
  logic [5:0]         ev;
  logic               irq_out, irq_oe, swap, adc1, adc2, strobe, cal_mode;
  logic [1:0]         wave_src;
  logic               test_mode;
  logic [9:0]         low_cfg;
  logic [5:0]         vec [5] = '{6'h20, 6'h10, 6'h08, 6'h02, 6'h01};
  logic [15:0]        exp [5] = '{16'h0080, 16'h0002, 16'h0002, 16'h0020, 16'h0001};
  logic [1:0]         srcs [4] = '{2'h0, 2'h2, 2'h3, 2'h2};
  integer             failures, comparisons, cycles, n;
  meter_mode_irq dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_energy_ovf(ev[5]), .i_sag_evt(ev[4]), .i_nozx_evt(ev[3]),
    .i_cal_done(ev[2]), .i_temp_done(ev[1]), .i_energy_msb(ev[0]), .i_zx_level(zx),
    .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .o_irq_out(irq_out), .o_irq_oe(irq_oe),
    .o_ch_swap(swap), .o_adc1_from_ch2(adc1), .o_adc2_from_ch1(adc2), .o_wave_src(wave_src),
    .o_wave_strobe(strobe), .o_cal_mode(cal_mode), .o_test_mode(test_mode), .o_low_cfg(low_cfg));
  host_model u_host (.i_mclk(i_mclk), .o_addr(reg_addr), .o_wdata(reg_wdata), .o_wr(reg_wr),
    .o_rd(reg_rd), .i_rdata(reg_rdata), .i_rvalid(reg_rvalid));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic fire(input logic [5:0] v);
    @(posedge i_mclk);
    ev <= v;
    @(posedge i_mclk);
    ev <= 6'h00;
  endtask
  task automatic settle(input integer k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  // Cycles until the next sample tick
  task automatic meas(output integer k);
    k = 0;
    do begin
      settle(1);
      k = k + 1;
    end while (strobe !== 1'b1);
  endtask
  task automatic conclude;
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      conclude;
    end
  end
  initial begin
    {i_arst_n, zx, ev} = '0;
    {failures, comparisons, cycles} = '0;
    repeat (4) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    u_host.rd(`OFS_OPCFG, s);
    chk(s, `OPCFG_RST);
    u_host.rd(`OFS_MASK, s);
    chk(s, {8'h00, `MASK_RST});
    u_host.wr(`OFS_MASK, 16'h00FF);
    u_host.rd(`OFS_MASK, s);
    chk(s, 16'h00BB);
    u_host.wr(`OFS_OPCFG, 16'h2000);
    u_host.service(s, c);
    settle(3);
    chk({14'h0, wave_src}, 16'h0001);
    chk({15'h0, irq_oe}, 16'h0000);
    fire(6'h04);
    u_host.service(s, c);
    chk(c, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      fire(vec[i]);
      settle(2);
      chk({15'h0, irq_oe}, 16'h0001);
      u_host.service(s, c);
      chk(s, exp[i]);
      chk(c, exp[i]);
      settle(1);
      chk({15'h0, irq_oe}, 16'h0000);
    end
    u_host.wr(`OFS_OPCFG, 16'h2480);
    u_host.rd(`OFS_OPCFG, s);
    chk(s, 16'h2480);
    chk({12'h0, swap, adc1, adc2, cal_mode}, 16'h000F);
    chk({6'h0, low_cfg}, 16'h0080);
    chk({15'h0, test_mode}, 16'h0000);
    fire(6'h04);
    u_host.service(s, c);
    chk(c, 16'h0002);
    @(posedge i_mclk);
    zx <= 1'b1;
    settle(3);
    chk({15'h0, irq_oe}, 16'h0001);
    u_host.service(s, c);
    chk(c, 16'h0010);
    @(posedge i_mclk);
    zx <= 1'b0;
    settle(3);
    chk({15'h0, irq_oe}, 16'h0000);
    u_host.rd(`OFS_FLAGS_RC, c);
    chk(c, 16'h0000);
    u_host.wr(`OFS_MASK, 16'h0000);
    fire(6'h20);
    u_host.service(s, c);
    chk(s, 16'h0080);
    chk({15'h0, irq_oe}, 16'h0000);
    for (int r = 0; r < 4; r++) begin
      u_host.wr(`OFS_OPCFG, {1'b0, srcs[r], 2'(r), 11'h000});
      meas(n);
      meas(n);
      chk(n[15:0], 16'(128 << r));
      chk({14'h0, wave_src}, {14'h0, srcs[r]});
      u_host.rd(`OFS_FLAGS, s);
      chk(s & 16'h0008, 16'h0008);
    end
    u_host.wr(`OFS_OPCFG, 16'h2000);
    settle(4);
    n = 0;
    repeat (1100) begin
      settle(1);
      n = n + (strobe === 1'b1);
    end
    chk(n[15:0], 16'h0000);
    conclude;
  end
endmodule // testbench
`default_nettype wire
